// ===== cc_i2c_slave.sv
// Control-channel bus slave with register file, translation and input forwarding
// Functional notes
// - Lines idle high; start is SDA fall, stop SDA rise, with SCL high.
// - One bit per SCL pulse; transmitter keeps SDA stable while SCL high.
// - Ninth pulse is acknowledge; receiver holds SDA low through its high phase.
// - Acknowledge regardless of lock unless lock-gated enable is cleared.
// - Answer bus address 100100X, then direction bit, 0 write, 1 read.
// - First written byte loads pointer; stop right after changes nothing else.
// - Following written bytes go to pointer location, pointer then increments.
// - Reads come from stored pointer, incrementing after each byte.
// - After master not-acknowledge the device stops driving data.
// - A start condition returns the bus state machine to its address state.
// - Two translation entries replace matching peripheral source addresses.
// - Broadcast reaches all translated peripherals; unique address only one. Code forwards a single remoteAddr, entry A winning if both match.
// - General input sampled, shown in 0x0E D4, forwarded within 0.35 ms.
// - Bit-error checker enabled by 0x04 D5.
// - Equalizer boost in 0x05 bits 3:0, codes up to 1011; off at power-up.
// - Sawtooth divider in 0x03 bits 5:0 sets spread modulation rate.
// - A foreign-address transaction starts a remote master request.
// - SCL held low while remote transaction pends; lines are open-drain.
`timescale 1ns/100ps
module cc_i2c_slave
  import cc_pkg::*;
#(
  parameter int GPI_DELAY_CYCLES = GPI_DELAY_CYC
)(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bus clock pin
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe_n,
  // Bus data pin
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe_n,
  // Address strap and link status
  input  wire logic       addrSel,
  input  wire logic       linkLocked,
  input  wire logic       lockGatedAckEn,
  // Remote master request
  output logic            remoteReq,
  output logic [6:0]      remoteAddr,
  output logic            remoteRead,
  input  wire logic       remoteDone,
  input  wire logic       remoteAck,
  // General input forwarding
  input  wire logic       generalInput,
  output logic            remoteGeneralOutput,
  // Configuration outputs
  output logic            bitErrorTestEn,
  output logic            eqEnable,
  output logic [3:0]      eqBoost,
  output logic [5:0]      sawtoothDivider,
  output logic [2:0]      remoteMasterRateSel
);
  // ==========================================================
  // Declarations
  logic [2:0] syncIn;
  logic       sclS, sdaS, gpiS, sclPrev, sdaPrev;
  logic       sclRise, sclFall, startCond, stopCond;
  cc_state_t  state;
  logic [7:0] shiftReg, txByte, pointer;
  logic [2:0] bitCnt;
  logic       byteDone, firstByte, sdaDrive, sclHold;
  logic       byteEnd, ownAddr, ackOk, ptrLoad, regWrite, ptrInc;
  logic [7:0] spreadReg, testReg, eqReg, srcA, dstA, srcB, dstB, rateReg, inReg;
  logic [7:0] rdData;

  // Read mux over the mapped registers; unmapped offsets read zero
  function automatic logic [7:0] readReg(input logic [7:0] addr);
    logic [7:0] val;
    val = 8'h00;
    unique case (addr)
      REG_SPREAD_DIVIDER:  val = spreadReg;
      REG_BIT_ERROR_TEST:  val = testReg;
      REG_EQUALIZER_BOOST: val = eqReg;
      REG_XLATE_SRC_A:     val = srcA;
      REG_XLATE_DST_A:     val = dstA;
      REG_XLATE_SRC_B:     val = srcB;
      REG_XLATE_DST_B:     val = dstB;
      REG_REMOTE_RATE:     val = rateReg;
      REG_INPUT_STATE:     val = inReg;
      default:             val = 8'h00;
    endcase
    return val;
  endfunction : readReg

  // ==========================================================
  // Pin sampling and condition detection
  cc_sync #(
    .WIDTH   (3),
    .RST_VAL (3'b110)
  ) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({sclIn, sdaIn, generalInput}),
    .syncOut (syncIn)
  );
  assign sclS = syncIn[2];
  assign sdaS = syncIn[1];
  assign gpiS = syncIn[0];

  // Previous samples for edge finding
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  assign sclRise   = sclS & ~sclPrev;
  assign sclFall   = ~sclS & sclPrev;
  assign startCond = sclS & sclPrev & sdaPrev & ~sdaS;
  assign stopCond  = sclS & sclPrev & ~sdaPrev & sdaS;

  // Byte the pointer selects, ready for the next read byte
  assign rdData = readReg(pointer);

  // ==========================================================
  // Byte-level decisions
  always_comb
  begin
    byteEnd  = sclFall & byteDone & (state == ST_ADDR || state == ST_RX);
    ownAddr  = shiftReg[7:1] == {DEV_ADDR_BASE, addrSel};
    ackOk    = lockGatedAckEn | linkLocked;
    ptrLoad  = (state == ST_RX) & byteEnd & firstByte;
    regWrite = (state == ST_RX) & byteEnd & ~firstByte;
    // No step on the read address acknowledge, so the first byte is the stored one
    ptrInc   = regWrite | ((state == ST_TX_ACK) & sclRise & ~firstByte);
  end

  // ==========================================================
  // Bus state machine; start and stop override every state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state     <= ST_IDLE;
      shiftReg  <= 8'h00;
      txByte    <= 8'h00;
      bitCnt    <= 3'h0;
      byteDone  <= 1'b0;
      firstByte <= 1'b0;
      sdaDrive  <= 1'b0;
      sclHold   <= 1'b0;
      remoteReq <= 1'b0;
      remoteAddr <= 7'h00;
      remoteRead <= 1'b0;
    end
    else
    begin
      remoteReq <= 1'b0;
      if (startCond)
      begin
        state    <= ST_ADDR;
        bitCnt   <= 3'h0;
        byteDone <= 1'b0;
        sdaDrive <= 1'b0;
        sclHold  <= 1'b0;
      end
      else if (stopCond)
      begin
        state    <= ST_IDLE;
        sdaDrive <= 1'b0;
        sclHold  <= 1'b0;
      end
      else
      begin
        unique case (state)
          ST_IDLE, ST_IGNORE:
          begin
            sdaDrive <= 1'b0;
          end
          ST_ADDR, ST_RX:
          begin
            // One bit taken per rising SCL edge
            if (sclRise)
            begin
              shiftReg <= {shiftReg[6:0], sdaS};
              bitCnt   <= bitCnt + 3'h1;
              byteDone <= (bitCnt == 3'h7);
            end
            else if (byteEnd && state == ST_ADDR && ownAddr)
            begin
              byteDone  <= 1'b0;
              firstByte <= 1'b1; // Pointer byte on a write, address ack on a read
              sdaDrive  <= ackOk;
              state     <= ackOk ? (shiftReg[0] ? ST_TX_ACK : ST_RX_ACK) : ST_IGNORE;
              remoteRead <= shiftReg[0];
            end
            else if (byteEnd && state == ST_ADDR)
            begin
              // Foreign address: pass to the remote master, translated if it matches entry A or B
              byteDone   <= 1'b0;
              remoteReq  <= 1'b1;
              remoteRead <= shiftReg[0];
              if (shiftReg[7:1] == srcA[6:0])
                remoteAddr <= dstA[6:0];
              else if (shiftReg[7:1] == srcB[6:0])
                remoteAddr <= dstB[6:0];
              else
                remoteAddr <= shiftReg[7:1];
              sclHold <= 1'b1;
              state   <= ST_FWD;
            end
            else if (byteEnd)
            begin
              byteDone  <= 1'b0;
              firstByte <= 1'b0;
              sdaDrive  <= ackOk;
              state     <= ackOk ? ST_RX_ACK : ST_IGNORE;
            end
          end
          ST_RX_ACK:
          begin
            // Released on the falling edge that ends the ninth pulse
            if (sclFall)
            begin
              sdaDrive <= 1'b0;
              bitCnt   <= 3'h0;
              state    <= ST_RX;
            end
          end
          ST_TX_ACK:
          begin
            // Next byte leaves on the fall that ends the ninth pulse
            if (sclFall)
            begin
              txByte    <= rdData;
              sdaDrive  <= ~rdData[7];
              bitCnt    <= 3'h0;
              firstByte <= 1'b0;
              state     <= ST_TX;
            end
            else if (sclRise && !firstByte && sdaS)
            begin
              state <= ST_IGNORE;
            end
          end
          ST_TX:
          begin
            // Data changes only after SCL has gone low again
            if (sclFall && bitCnt == 3'h7)
            begin
              sdaDrive  <= 1'b0;
              firstByte <= 1'b0;
              state     <= ST_TX_ACK;
            end
            else if (sclFall)
            begin
              txByte   <= {txByte[6:0], 1'b0};
              sdaDrive <= ~txByte[6];
              bitCnt   <= bitCnt + 3'h1;
            end
          end
          ST_FWD:
          begin
            if (remoteDone)
            begin
              sclHold  <= 1'b0;
              sdaDrive <= remoteAck;
              state    <= ST_FWD_ACK;
            end
          end
          ST_FWD_ACK:
          begin
            if (sclFall)
            begin
              sdaDrive <= 1'b0;
              state    <= ST_IGNORE;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Register pointer; eight bits, wraps naturally
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pointer <= 8'h00;
    else if (ptrLoad)
      pointer <= shiftReg;
    else if (ptrInc)
      pointer <= pointer + 8'h01;
  end

  // ==========================================================
  // Register file; unmapped writes are dropped
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      spreadReg <= RST_SPREAD_DIVIDER;
      testReg   <= RST_BIT_ERROR_TEST;
      eqReg     <= RST_EQUALIZER_BOOST;
      srcA      <= RST_XLATE;
      dstA      <= RST_XLATE;
      srcB      <= RST_XLATE;
      dstB      <= RST_XLATE;
      rateReg   <= RST_REMOTE_RATE;
      inReg     <= RST_INPUT_STATE;
    end
    else
    begin
      if (regWrite)
      begin
        unique case (pointer)
          REG_SPREAD_DIVIDER:  spreadReg <= shiftReg;
          REG_BIT_ERROR_TEST:  testReg   <= shiftReg;
          REG_EQUALIZER_BOOST: eqReg     <= shiftReg;
          REG_XLATE_SRC_A:     srcA      <= shiftReg;
          REG_XLATE_DST_A:     dstA      <= shiftReg;
          REG_XLATE_SRC_B:     srcB      <= shiftReg;
          REG_XLATE_DST_B:     dstB      <= shiftReg;
          REG_REMOTE_RATE:     rateReg   <= shiftReg;
          REG_INPUT_STATE:     inReg     <= shiftReg;
          default:             inReg     <= inReg;
        endcase
      end
      // Input state bit is hardware-owned; assigned after the case so it wins
      inReg[GENERAL_INPUT_POS] <= gpiS;
    end
  end

  // ==========================================================
  // General input forwarding; low from reset, follows the synchronised input one clock later
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      remoteGeneralOutput <= 1'b0;
    else
      remoteGeneralOutput <= gpiS;
  end

  // ==========================================================
  // Pin and configuration outputs; open-drain, only ever pulls low
  assign sdaOut              = 1'b0;
  assign sclOut              = 1'b0;
  assign sdaOe_n             = ~sdaDrive;
  assign sclOe_n             = ~sclHold;
  assign bitErrorTestEn      = testReg[BIT_ERROR_TEST_EN_POS];
  assign eqEnable            = eqReg[EQ_ENABLE_POS];
  assign eqBoost             = eqReg[EQ_BOOST_MSB:0];
  assign sawtoothDivider     = spreadReg[SAWTOOTH_MSB:0];
  assign remoteMasterRateSel = rateReg[RATE_SEL_MSB:0];

  // ==========================================================
  // Checks
  logic [31:0] gpiLag;
  always_ff @(posedge clk)
  begin
    if (!rst_n || remoteGeneralOutput == gpiS)
      gpiLag <= 32'h0000_0000;
    else
      gpiLag <= gpiLag + 32'h0000_0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_start_resets: assert property (startCond |=> state == ST_ADDR)
    else $error("start did not return machine to address state");
  a_stop_frees: assert property (stopCond |=> state == ST_IDLE)
    else $error("stop did not free the bus");
  a_ack_held: assert property (
      (state == ST_RX_ACK && sclS) |-> sdaDrive)
    else $error("acknowledge released during high phase");
  a_tx_stable: assert property (
      (state == ST_TX && sclS && sclPrev) |-> $stable(sdaDrive))
    else $error("transmit data changed while clock high");
  a_lock_gate: assert property (
      (byteEnd && !ackOk) |=> !sdaDrive)
    else $error("acknowledge given without lock while gated");
  a_ptr_load: assert property (ptrLoad |=> pointer == $past(shiftReg))
    else $error("pointer byte not loaded");
  a_ptr_step: assert property (
      (ptrInc && !ptrLoad) |=> pointer == $past(pointer) + 8'h01)
    else $error("pointer did not advance by one");
  a_nack_quiet: assert property (
      (state == ST_IGNORE) |-> !sdaDrive ##1 !sdaDrive)
    else $error("device drives data after not-acknowledge");
  a_gpi_delay: assert property (gpiLag < GPI_DELAY_CYCLES)
    else $error("remote output lags general input too long");
  a_stretch_fwd: assert property (
      sclHold |-> (state == ST_FWD))
    else $error("clock held outside remote transaction");
endmodule : cc_i2c_slave

// ===== cc_pkg.sv
// Constants, register map and state type of the control-channel slave
package cc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] REG_SPREAD_DIVIDER  = 8'h03;
  localparam logic [7:0] REG_BIT_ERROR_TEST  = 8'h04;
  localparam logic [7:0] REG_EQUALIZER_BOOST = 8'h05;
  localparam logic [7:0] REG_XLATE_SRC_A     = 8'h09;
  localparam logic [7:0] REG_XLATE_DST_A     = 8'h0a;
  localparam logic [7:0] REG_XLATE_SRC_B     = 8'h0b;
  localparam logic [7:0] REG_XLATE_DST_B     = 8'h0c;
  localparam logic [7:0] REG_REMOTE_RATE     = 8'h0d;
  localparam logic [7:0] REG_INPUT_STATE     = 8'h0e;
  // ==========================================================
  // Field positions
  localparam int BIT_ERROR_TEST_EN_POS = 5;
  localparam int GENERAL_INPUT_POS     = 4;
  localparam int EQ_ENABLE_POS         = 4;
  localparam int EQ_BOOST_MSB          = 3;
  localparam int SAWTOOTH_MSB          = 5;
  localparam int RATE_SEL_MSB          = 2;
  localparam logic [3:0] EQ_BOOST_MAX  = 4'hb;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_SPREAD_DIVIDER  = 8'h00;
  localparam logic [7:0] RST_BIT_ERROR_TEST  = 8'h00;
  localparam logic [7:0] RST_EQUALIZER_BOOST = 8'h09;
  localparam logic [7:0] RST_XLATE           = 8'h00;
  localparam logic [7:0] RST_REMOTE_RATE     = 8'h00;
  localparam logic [7:0] RST_INPUT_STATE     = 8'h00;
  // ==========================================================
  // Bus address and timing
  localparam logic [5:0] DEV_ADDR_BASE   = 6'h24;
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         GPI_DELAY_NS    = 350000;
  localparam int         GPI_DELAY_CYC   = GPI_DELAY_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Slave states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK,
    ST_FWD, ST_FWD_ACK, ST_IGNORE
  } cc_state_t;
endpackage : cc_pkg

// ===== cc_sync.sv
// Two-flop synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/100ps
module cc_sync
  import cc_pkg::*;
#(
  parameter int                 WIDTH   = 1,
  parameter logic [WIDTH-1:0]   RST_VAL = '0
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // ==========================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1  <= RST_VAL;
      syncOut <= RST_VAL;
    end
    else
    begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule : cc_sync

// ===== cc_i2c_master_model.sv
// Behavioural bus master standing in for the local microcontroller
`timescale 1ns/100ps
module cc_i2c_master_model (
  // Wire levels
  input  wire logic sclLine,
  input  wire logic sdaLine,
  // Open-drain drives, 1 releases the wire
  output logic      sclRel,
  output logic      sdaRel
);
  // ==========================================================
  // Line control
  // Both lines released while idle; SCL stands still between frames
  initial
  begin
    sclRel = 1'b1;
    sdaRel = 1'b1;
  end
  // Release SCL, bounded wait so a stuck stretch cannot hang the run
  task automatic sclHigh();
    int n;
    n = 0;
    sclRel = 1'b1;
    #10;
    while (sclLine !== 1'b1 && n < 5000)
    begin
      #10;
      n++;
    end
  endtask : sclHigh
  // One bit: data set in the low phase, held through the high phase
  task automatic bitXfer(input logic b, output logic s);
    #20 sdaRel = b;
    #20 sclHigh();
    #20 s = sdaLine;
    #10 sclRel = 1'b0;
  endtask : bitXfer
  // ==========================================================
  // Framing
  // Start or repeated start; waits first so the slave lets go of SDA
  task automatic start();
    #40 sdaRel = 1'b1;
    if (sclRel === 1'b0)
      #20 sclHigh();
    #20 sdaRel = 1'b0;
    #40 sclRel = 1'b0;
  endtask : start
  // Stop, then the bus stands idle
  task automatic stop();
    #20 sdaRel = 1'b0;
    #20 sclHigh();
    #20 sdaRel = 1'b1;
    #40;
  endtask : stop
  // Byte out, ninth pulse with SDA released; longer low phase at byte edges
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    #40;
    for (int i = 7; i >= 0; i--)
      bitXfer(d[i], s);
    #40 bitXfer(1'b1, ack);
  endtask : sendByte
  // Byte in, then our own ack or nack on the ninth pulse
  task automatic recvByte(output logic [7:0] d, input logic nack);
    logic s;
    #40;
    for (int i = 7; i >= 0; i--)
      bitXfer(1'b1, d[i]);
    #40 bitXfer(nack, s);
  endtask : recvByte
endmodule : cc_i2c_master_model

// ===== control_channel_i2c_slave_bench.sv
// Self-checking bench for the control-channel slave
`timescale 1ns/100ps
module control_channel_i2c_slave_bench
  import cc_pkg::*;
;
  localparam int GPI_CYC = 50;
  logic       clk, rst_n, sclRel, sdaRel, sclOut, sclOe_n, sdaOut, sdaOe_n;
  logic       addrSel, linkLocked, lockGatedAckEn, remoteReq, remoteRead;
  logic       generalInput, remoteGeneralOutput;
  logic       remoteDone = 1'b0;
  logic       remoteAck  = 1'b1;
  logic       bitErrorTestEn, eqEnable, seenRead, ack;
  logic [6:0] remoteAddr, seenAddr, fa;
  logic [3:0] eqBoost;
  logic [5:0] sawtoothDivider;
  logic [2:0] remoteMasterRateSel;
  logic [7:0] rx;
  logic [7:0] shadow [0:255];
  logic [7:0] wbuf [0:15];
  wire        sclWire, sdaWire;
  int         n_errors, total_checks;
  // ==========================================================
  // Wires, design and bus master
  // Open-drain lines with pull-ups
  assign sclWire = sclRel & (sclOe_n | sclOut);
  assign sdaWire = sdaRel & (sdaOe_n | sdaOut);
  cc_i2c_slave #(.GPI_DELAY_CYCLES(GPI_CYC)) dut_u (
    .clk(clk), .rst_n(rst_n), .sclIn(sclWire), .sclOut(sclOut), .sclOe_n(sclOe_n),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addrSel(addrSel),
    .linkLocked(linkLocked), .lockGatedAckEn(lockGatedAckEn), .remoteReq(remoteReq),
    .remoteAddr(remoteAddr), .remoteRead(remoteRead), .remoteDone(remoteDone),
    .remoteAck(remoteAck), .generalInput(generalInput),
    .remoteGeneralOutput(remoteGeneralOutput), .bitErrorTestEn(bitErrorTestEn),
    .eqEnable(eqEnable), .eqBoost(eqBoost), .sawtoothDivider(sawtoothDivider),
    .remoteMasterRateSel(remoteMasterRateSel));
  cc_i2c_master_model mst_u (
    .sclLine(sclWire), .sdaLine(sdaWire), .sclRel(sclRel), .sdaRel(sdaRel));
  always #5 clk = ~clk;
  // Remote side answers each forwarded request after a pending delay
  always @(negedge clk)
    if (remoteReq === 1'b1)
    begin
      seenAddr = remoteAddr;
      seenRead = remoteRead;
      repeat (20) @(negedge clk);
      chk({7'h0, sclOe_n}, 8'h00);
      remoteAck  = 1'($urandom);
      remoteDone = 1'b1;
      @(negedge clk);
      remoteDone = 1'b0;
    end
  // ==========================================================
  // Checking and expectations
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  function automatic logic mapped(input logic [7:0] a);
    return a inside {[8'h03:8'h05], [8'h09:8'h0e]};
  endfunction : mapped
  // Unmapped places read zero; the input bit always shows the pin
  function automatic logic [7:0] expRead(input logic [7:0] a);
    logic [7:0] v;
    v = mapped(a) ? shadow[a] : 8'h00;
    if (a == REG_INPUT_STATE)
      v[GENERAL_INPUT_POS] = generalInput;
    return v;
  endfunction : expRead
  task automatic chkCfg();
    repeat (4) @(negedge clk);
    chk({2'b0, sawtoothDivider}, {2'b0, shadow[3][5:0]});
    chk({7'h0, bitErrorTestEn}, {7'h0, shadow[4][5]});
    chk({3'b0, eqEnable, eqBoost}, {3'b0, shadow[5][4:0]});
    chk({5'h0, remoteMasterRateSel}, {5'h0, shadow[13][2:0]});
  endtask : chkCfg
  // ==========================================================
  // Transactions
  task automatic wrRegs(input logic [7:0] ptr, input int n);
    mst_u.start();
    mst_u.sendByte({DEV_ADDR_BASE, addrSel, 1'b0}, ack);
    chk({7'h0, ack}, 8'h00);
    mst_u.sendByte(ptr, ack);
    chk({7'h0, ack}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      mst_u.sendByte(wbuf[i], ack);
      if (mapped(ptr))
        shadow[ptr] = wbuf[i];
      ptr++;
    end
    mst_u.stop();
    chkCfg();
  endtask : wrRegs
  task automatic rdRegs(input logic [7:0] ptr, input int n, input logic setPtr);
    if (setPtr)
    begin
      mst_u.start();
      mst_u.sendByte({DEV_ADDR_BASE, addrSel, 1'b0}, ack);
      mst_u.sendByte(ptr, ack);
    end
    mst_u.start();
    mst_u.sendByte({DEV_ADDR_BASE, addrSel, 1'b1}, ack);
    chk({7'h0, ack}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      mst_u.recvByte(rx, i == n - 1);
      chk(rx, expRead(ptr));
      ptr++;
    end
    repeat (8) @(negedge clk);
    chk({7'h0, sdaOe_n}, 8'h01);
    mst_u.stop();
  endtask : rdRegs
  task automatic fgn(input logic [6:0] a, input logic rd, input logic [6:0] expA);
    seenAddr = ~expA;
    mst_u.start();
    mst_u.sendByte({a, rd}, ack);
    chk({7'h0, ack}, {7'h0, ~remoteAck});
    chk({1'b0, seenAddr}, {1'b0, expA});
    chk({7'h0, seenRead}, {7'h0, rd});
    mst_u.stop();
  endtask : fgn
  // ==========================================================
  // Main sequence
  initial
  begin
    {clk, rst_n, linkLocked, generalInput} = '0;
    lockGatedAckEn = 1'b1;
    n_errors = 0;
    total_checks = 0;
    rx = 8'($urandom(6));
    addrSel = 1'($urandom);
    foreach (shadow[i])
      shadow[i] = 8'h00;
    shadow[REG_EQUALIZER_BOOST] = RST_EQUALIZER_BOOST;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({7'h0, remoteGeneralOutput}, 8'h00);
    chkCfg();
    rdRegs(8'h03, 12, 1'b1);
    wrRegs(8'h05, 0);
    rdRegs(8'h05, 2, 1'b0);
    for (int i = 0; i < 12; i++)
      wbuf[i] = 8'($urandom);
    wbuf[2][3:0] = 4'($urandom % 12); // boost codes 0000..1011 only
    wrRegs(8'h03, 12);
    rdRegs(8'h03, 12, 1'b1);
    for (int i = 0; i < 6; i++)
      wbuf[i] = 8'($urandom);
    wrRegs(8'hfe, 6);
    wbuf[0] = {3'b000, 5'($urandom)};
    wbuf[1] = {1'b0, 7'($urandom)};
    wbuf[2] = {3'b001, 5'($urandom)};
    wbuf[3] = {1'b0, 7'($urandom)};
    wrRegs(8'h09, 4);
    fa = {2'b11, 5'($urandom)};
    fgn(wbuf[0][6:0], 1'b0, wbuf[1][6:0]);
    fgn(wbuf[2][6:0], 1'b1, wbuf[3][6:0]);
    fgn(fa, 1'b0, fa);
    fgn({DEV_ADDR_BASE, ~addrSel}, 1'b1, {DEV_ADDR_BASE, ~addrSel});
    lockGatedAckEn = 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      linkLocked = k[0];
      mst_u.start();
      mst_u.sendByte({DEV_ADDR_BASE, addrSel, 1'b0}, ack);
      chk({7'h0, ack}, {7'h0, ~k[0]});
      mst_u.stop();
    end
    // Transitions spaced wider than the forwarding delay
    for (int k = 0; k < 4; k++)
    begin
      generalInput = k[0] ? 1'($urandom) : ~generalInput;
      repeat (GPI_CYC + 10) @(negedge clk);
      chk({7'h0, remoteGeneralOutput}, {7'h0, generalInput});
    end
    rdRegs(REG_INPUT_STATE, 1, 1'b1);
    stop_test();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #400000;
    n_errors++;
    stop_test();
  end
endmodule : control_channel_i2c_slave_bench
